/* File: rcs_pkg.sv */
// constants, types and register map of the clock control and status block
//
// Overview of operation
// - with daylight saving, 1:59:59 jumps to 3:00:00 on the first Sunday in April
// - daylight saving falls back to 1:00:00 in October
// - ctrl_b bit 1 picks 12 or 24 hours
// - data_format_sel picks BCD or binary values
// - ctrl_b bit 3 always reads zero
// - master reset keeps format and freeze bits
// - master reset clears the three interrupt enables
// - update_int_en raises interrupt on each update
// - alarm_int_en raises interrupt on time match
// - periodic_int_en raises interrupt at rate_select rate
// - freeze bit holds the visible time still
// - irq_flags bits 3..0 always read zero
// - update flag set on update, read clears
// - alarm flag set on match, read clears
// - periodic flag set on tap, read clears
// - summary flag is any enabled flag set
// - interrupt pin is inverse of summary flag
// - ctrl_d bits 6..0 always read zero
// - valid_ram_time reads zero after supply drop
// - reading ctrl_d sets valid_ram_time again
// - writes refused until ctrl_d read once
// - rate_select picks one of thirteen taps, codes 1 and 2 repeat codes 8 and 9
// - repeated events before service are lost
package rcs_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CORE_HZ = 250_000_000;
  localparam int unsigned BASE_HZ = 32_768;
  localparam int unsigned BASE_DIV = CORE_HZ / BASE_HZ;
  localparam logic [14:0] CHAIN_LAST = 15'h7fff;

  // ****************************************************************
  // register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [7:0] IDX_SEC = 8'h00;
  localparam logic [7:0] IDX_ALM_SEC = 8'h01;
  localparam logic [7:0] IDX_MIN = 8'h02;
  localparam logic [7:0] IDX_ALM_MIN = 8'h03;
  localparam logic [7:0] IDX_HOUR = 8'h04;
  localparam logic [7:0] IDX_ALM_HOUR = 8'h05;
  localparam logic [7:0] IDX_DOW = 8'h06;
  localparam logic [7:0] IDX_DATE = 8'h07;
  localparam logic [7:0] IDX_MONTH = 8'h08;
  localparam logic [7:0] IDX_CTRL_A = 8'h0a;
  localparam logic [7:0] IDX_CTRL_B = 8'h0b;
  localparam logic [7:0] IDX_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_VALID = 8'h0d;

  // ****************************************************************
  // field values
  // ****************************************************************
  localparam logic [1:0] ALM_DONT_CARE = 2'h3;
  localparam logic [2:0] DOW_SUNDAY = 3'h1;
  localparam logic [3:0] MONTH_APR = 4'h4;
  localparam logic [3:0] MONTH_OCT = 4'ha;
  localparam logic [4:0] FIRST_WEEK_END = 5'h07;
  localparam logic [4:0] LAST_WEEK_START = 5'h19;
  localparam logic [4:0] HOUR_DST_AT = 5'h01;
  localparam logic [4:0] HOUR_SPRING_TO = 5'h03;
  localparam logic [4:0] HOUR_FALL_TO = 5'h01;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [3:0] RATE_NONE = 4'h0;
  localparam logic [7:0] CTRL_B_RESET = 8'h02;
  localparam logic [3:0] RATE_RESET = 4'h6;

  typedef struct packed {
    logic freeze;
    logic periodic_int_en;
    logic alarm_int_en;
    logic update_int_en;
    logic unused;
    logic data_format_sel;
    logic hour_24;
    logic daylight_saving_en;
  } rcs_ctrl_b_t;

  typedef struct packed {
    logic [3:0] month;
    logic [4:0] date;
    logic [2:0] dow;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } rcs_time_t;

  localparam rcs_time_t TIME_RESET = '{4'h1, 5'h01, 3'h1, 5'h00, 6'h00,
                                       6'h00};

endpackage

/* File: rcs_ctrl.sv */
// clock control, interrupt flag and supply validity registers
`timescale 1ns/100ps
module rcs_ctrl
  import rcs_pkg::*;
#(
  parameter int unsigned BASE_DIV_P = BASE_DIV
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_por_n,
  input wire logic i_supply_low,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  output logic o_irq_n
);

  if (BASE_DIV_P < 1 || BASE_DIV_P > 8192) begin : g_bad_div
    $error("BASE_DIV_P must be 1 to 8192");
  end

  // ****************************************************************
  // value conversion
  // ****************************************************************
  function automatic logic [7:0] enc(input logic [6:0] v, input logic bin);
    logic [6:0] t;
    t = v / 7'd10;
    if (bin) begin
      return {1'b0, v};
    end
    return {t[3:0], 4'(v - 7'(t * 7'd10))};
  endfunction

  function automatic logic [6:0] dec(input logic [7:0] b, input logic bin);
    if (bin) begin
      return b[6:0];
    end
    return 7'(b[7:4] * 7'd10 + {3'h0, b[3:0]});
  endfunction

  function automatic logic [7:0] hour_out(input logic [4:0] h,
                                          input logic h24, input logic bin);
    logic [4:0] h12;
    logic [7:0] e;
    h12 = (h == 5'd0) ? 5'd12 : ((h > 5'd12) ? 5'(h - 5'd12) : h);
    e = enc({2'h0, h12}, bin);
    if (h24) begin
      return enc({2'h0, h}, bin);
    end
    return {(h >= 5'd12), e[6:0]};
  endfunction

  function automatic logic [4:0] hour_in(input logic [7:0] b,
                                         input logic h24, input logic bin);
    logic [4:0] v;
    v = 5'(dec({1'b0, b[6:0]}, bin));
    if (h24) begin
      return 5'(dec(b, bin));
    end
    if (b[7]) begin
      return (v == 5'd12) ? v : 5'(v + 5'd12);
    end
    return (v == 5'd12) ? 5'd0 : v;
  endfunction

  function automatic logic [14:0] tap_mask(input logic [3:0] rs);
    logic [3:0] n;
    n = (rs < 4'h3) ? 4'(rs + 4'h6) : 4'(rs - 4'h1);
    return 15'((16'h1 << n) - 16'h1);
  endfunction

  function automatic logic [4:0] days_in(input logic [3:0] m);
    if (m == 4'h2) begin
      return 5'd28;
    end else if (m == 4'h4 || m == 4'h6 || m == 4'h9 || m == 4'hb) begin
      return 5'd30;
    end
    return 5'd31;
  endfunction

  function automatic logic alm_hit(input logic [7:0] a, input logic [7:0] c);
    return (a[7:6] == ALM_DONT_CARE) || (a == c);
  endfunction

  // ****************************************************************
  // bus slave
  // ****************************************************************
  logic acc;
  logic acc_rd;
  logic [7:0] acc_idx;
  logic dph_wr_q;
  logic [7:0] dph_idx_q;
  logic wr_en;
  logic [7:0] wdat;
  logic [7:0] rd_d;
  logic unlock_q;

  assign acc = i_hsel && i_htrans[1] && i_hready && (i_hsize == HSIZE_WORD)
               && (i_haddr[1:0] == 2'h0);
  assign acc_rd = acc && !i_hwrite;
  assign acc_idx = {2'h0, i_haddr[7:2]};
  assign wr_en = dph_wr_q && unlock_q;
  assign wdat = i_hwdata[7:0];
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      dph_wr_q <= 1'b0;
      dph_idx_q <= 8'h00;
    end else begin
      dph_wr_q <= acc && i_hwrite;
      dph_idx_q <= acc_idx;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_hrdata <= 32'h0000_0000;
    end else if (acc_rd) begin
      o_hrdata <= {24'h00_0000, rd_d};
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  rcs_ctrl_b_t ctrl_b_q;
  logic [3:0] opt_q;
  logic [2:0] int_en_q;
  logic [3:0] rate_select_q;
  logic [7:0] alm_sec_q;
  logic [7:0] alm_min_q;
  logic [7:0] alm_hour_q;

  always_ff @(posedge i_core_clk) begin
    if (!i_por_n) begin
      opt_q <= {CTRL_B_RESET[7], CTRL_B_RESET[2:0]};
    end else if (wr_en && dph_idx_q == IDX_CTRL_B) begin
      opt_q[3] <= wdat[7];
      opt_q[2] <= wdat[2];
      opt_q[1] <= wdat[1];
      opt_q[0] <= wdat[0];
    end
  end
  assign ctrl_b_q = {opt_q[3], int_en_q, 1'b0, opt_q[2:0]};

  always_ff @(posedge i_core_clk) begin
    if (!i_por_n || !i_rst_n) begin
      int_en_q <= 3'h0;
    end else if (wr_en && dph_idx_q == IDX_CTRL_B) begin
      int_en_q <= wdat[6:4];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_por_n) begin
      rate_select_q <= RATE_RESET;
      alm_sec_q <= 8'h00;
      alm_min_q <= 8'h00;
      alm_hour_q <= 8'h00;
    end else if (wr_en) begin
      if (dph_idx_q == IDX_CTRL_A) begin
        rate_select_q <= wdat[3:0];
      end else if (dph_idx_q == IDX_ALM_SEC) begin
        alm_sec_q <= wdat;
      end else if (dph_idx_q == IDX_ALM_MIN) begin
        alm_min_q <= wdat;
      end else if (dph_idx_q == IDX_ALM_HOUR) begin
        alm_hour_q <= wdat;
      end
    end
  end

  // ****************************************************************
  // time base and divider chain
  // ****************************************************************
  logic [12:0] base_cnt_q;
  logic base_tick;
  logic [14:0] chain_q;
  logic sec_tick;
  logic per_evt;

  assign base_tick = (base_cnt_q == 13'(BASE_DIV_P - 1));
  assign sec_tick = base_tick && (chain_q == CHAIN_LAST);
  assign per_evt = base_tick && (rate_select_q != RATE_NONE)
                   && ((chain_q & tap_mask(rate_select_q))
                       == tap_mask(rate_select_q));

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      base_cnt_q <= 13'h0000;
    end else begin
      base_cnt_q <= base_tick ? 13'h0000 : 13'(base_cnt_q + 13'h0001);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      chain_q <= 15'h0000;
    end else if (base_tick) begin
      chain_q <= 15'(chain_q + 15'h0001);
    end
  end

  // ****************************************************************
  // time keeping
  // ****************************************************************
  rcs_time_t time_q;
  rcs_time_t time_d;
  logic fell_q;
  logic fall_now;
  logic upd_evt;
  logic bin;

  assign bin = ctrl_b_q.data_format_sel;
  assign upd_evt = sec_tick && !ctrl_b_q.freeze;

  always_comb begin
    time_d = time_q;
    fall_now = 1'b0;
    time_d.sec = 6'(time_q.sec + 6'd1);
    if (time_q.sec == 6'd59) begin
      time_d.sec = 6'd0;
      time_d.min = 6'(time_q.min + 6'd1);
      if (time_q.min == 6'd59) begin
        time_d.min = 6'd0;
        time_d.hour = 5'(time_q.hour + 5'd1);
        if (time_q.hour == 5'd23) begin
          time_d.hour = 5'd0;
          time_d.dow = (time_q.dow == 3'd7) ? 3'd1 : 3'(time_q.dow + 3'd1);
          time_d.date = 5'(time_q.date + 5'd1);
          if (time_q.date == days_in(time_q.month)) begin
            time_d.date = 5'd1;
            time_d.month = (time_q.month == 4'd12) ? 4'd1 :
                           4'(time_q.month + 4'd1);
          end
        end else if (ctrl_b_q.daylight_saving_en
                     && time_q.hour == HOUR_DST_AT
                     && time_q.dow == DOW_SUNDAY) begin
          if (time_q.month == MONTH_APR
              && time_q.date <= FIRST_WEEK_END) begin
            time_d.hour = HOUR_SPRING_TO;
          end else if (time_q.month == MONTH_OCT
                       && time_q.date >= LAST_WEEK_START && !fell_q) begin
            time_d.hour = HOUR_FALL_TO;
            fall_now = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_por_n) begin
      fell_q <= 1'b0;
    end else if (upd_evt) begin
      fell_q <= fall_now || (fell_q && time_d.date == time_q.date);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_por_n) begin
      time_q <= TIME_RESET;
    end else if (wr_en && dph_idx_q == IDX_SEC) begin
      time_q.sec <= 6'(dec(wdat, bin));
    end else if (wr_en && dph_idx_q == IDX_MIN) begin
      time_q.min <= 6'(dec(wdat, bin));
    end else if (wr_en && dph_idx_q == IDX_HOUR) begin
      time_q.hour <= hour_in(wdat, ctrl_b_q.hour_24, bin);
    end else if (wr_en && dph_idx_q == IDX_DOW) begin
      time_q.dow <= 3'(dec(wdat, bin));
    end else if (wr_en && dph_idx_q == IDX_DATE) begin
      time_q.date <= 5'(dec(wdat, bin));
    end else if (wr_en && dph_idx_q == IDX_MONTH) begin
      time_q.month <= 4'(dec(wdat, bin));
    end else if (upd_evt) begin
      time_q <= time_d;
    end
  end

  // ****************************************************************
  // alarm compare, one cycle after the update
  // ****************************************************************
  logic upd_dly_q;
  logic alm_evt;
  logic [7:0] sec_vis;
  logic [7:0] min_vis;
  logic [7:0] hour_vis;

  assign sec_vis = enc({1'b0, time_q.sec}, bin);
  assign min_vis = enc({1'b0, time_q.min}, bin);
  assign hour_vis = hour_out(time_q.hour, ctrl_b_q.hour_24, bin);
  assign alm_evt = upd_dly_q && alm_hit(alm_sec_q, sec_vis)
                   && alm_hit(alm_min_q, min_vis)
                   && alm_hit(alm_hour_q, hour_vis);

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      upd_dly_q <= 1'b0;
    end else begin
      upd_dly_q <= upd_evt;
    end
  end

  // ****************************************************************
  // interrupt flags
  // ****************************************************************
  logic [2:0] flag_q;
  logic [2:0] evt;
  logic [2:0] en;
  logic rd_flags;
  logic irq_summary_flag;

  assign evt = {per_evt, alm_evt, upd_evt};
  assign en = {ctrl_b_q.periodic_int_en, ctrl_b_q.alarm_int_en,
               ctrl_b_q.update_int_en};
  assign rd_flags = acc_rd && acc_idx == IDX_FLAGS;
  assign irq_summary_flag = |(flag_q & en);
  assign o_irq_n = !irq_summary_flag;

  for (genvar i = 0; i < 3; i++) begin : g_flag
    always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
        flag_q[i] <= 1'b0;
      end else begin
        flag_q[i] <= evt[i] || (flag_q[i] && !rd_flags);
      end
    end
  end

  // ****************************************************************
  // supply validity
  // ****************************************************************
  logic valid_ram_time_q;
  logic rd_valid;

  assign rd_valid = acc_rd && acc_idx == IDX_VALID;

  always_ff @(posedge i_core_clk) begin
    if (!i_por_n || i_supply_low) begin
      valid_ram_time_q <= 1'b0;
    end else if (rd_valid) begin
      valid_ram_time_q <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_por_n) begin
      unlock_q <= 1'b0;
    end else if (rd_valid) begin
      unlock_q <= 1'b1;
    end
  end

  // ****************************************************************
  // read decode
  // ****************************************************************
  always_comb begin
    if (acc_idx == IDX_SEC) begin
      rd_d = sec_vis;
    end else if (acc_idx == IDX_MIN) begin
      rd_d = min_vis;
    end else if (acc_idx == IDX_HOUR) begin
      rd_d = hour_vis;
    end else if (acc_idx == IDX_DOW) begin
      rd_d = enc({4'h0, time_q.dow}, bin);
    end else if (acc_idx == IDX_DATE) begin
      rd_d = enc({2'h0, time_q.date}, bin);
    end else if (acc_idx == IDX_MONTH) begin
      rd_d = enc({3'h0, time_q.month}, bin);
    end else if (acc_idx == IDX_ALM_SEC) begin
      rd_d = alm_sec_q;
    end else if (acc_idx == IDX_ALM_MIN) begin
      rd_d = alm_min_q;
    end else if (acc_idx == IDX_ALM_HOUR) begin
      rd_d = alm_hour_q;
    end else if (acc_idx == IDX_CTRL_A) begin
      rd_d = {4'h0, rate_select_q};
    end else if (acc_idx == IDX_CTRL_B) begin
      rd_d = ctrl_b_q;
    end else if (acc_idx == IDX_FLAGS) begin
      rd_d = {irq_summary_flag, flag_q, 4'h0};
    end else if (acc_idx == IDX_VALID) begin
      rd_d = {valid_ram_time_q, 7'h00};
    end else begin
      rd_d = 8'h00;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n || !i_por_n);

  property p_flags_read;
    rd_flags |=> o_hrdata[7] == $past(irq_summary_flag)
                 && o_hrdata[3:0] == 4'h0;
  endproperty
  a_flags_read: assert property (p_flags_read)
    else $error("flags read data wrong");

  property p_irq_pin;
    (flag_q[0] && ctrl_b_q.update_int_en) |-> !o_irq_n;
  endproperty
  a_irq_pin: assert property (p_irq_pin)
    else $error("interrupt pin not low");

  property p_ctrl_b_bit3;
    (acc_rd && acc_idx == IDX_CTRL_B) |=> !o_hrdata[3];
  endproperty
  a_ctrl_b_bit3: assert property (p_ctrl_b_bit3)
    else $error("ctrl_b bit 3 read as one");

  property p_valid_low;
    (acc_rd && acc_idx == IDX_VALID) |=> o_hrdata[6:0] == 7'h00;
  endproperty
  a_valid_low: assert property (p_valid_low)
    else $error("ctrl_d reserved bits nonzero");

  property p_update_flag;
    upd_evt |=> flag_q[0] ##1 (flag_q[0] || $past(rd_flags));
  endproperty
  a_update_flag: assert property (p_update_flag)
    else $error("update flag not held");

  property p_alarm_clear;
    (rd_flags && !alm_evt) |=> !flag_q[1];
  endproperty
  a_alarm_clear: assert property (p_alarm_clear)
    else $error("alarm flag not cleared");

  property p_supply_drop;
    i_supply_low |=> !valid_ram_time_q;
  endproperty
  a_supply_drop: assert property (p_supply_drop)
    else $error("valid bit survived supply drop");

  property p_valid_set;
    (rd_valid && !i_supply_low) |=> valid_ram_time_q;
  endproperty
  a_valid_set: assert property (p_valid_set)
    else $error("valid bit not set by read");

  property p_write_lock;
    (dph_wr_q && !unlock_q && !upd_evt) |=> $stable(ctrl_b_q)
                                            && $stable(time_q);
  endproperty
  a_write_lock: assert property (p_write_lock)
    else $error("write taken before unlock");

  property p_freeze;
    ctrl_b_q.freeze && !dph_wr_q |=> $stable(time_q);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("time moved while frozen");

  c_irq: cover property (!o_irq_n ##1 rd_flags ##1 o_irq_n);
  c_alarm: cover property (alm_evt);
  c_periodic: cover property (per_evt && ctrl_b_q.periodic_int_en);
  c_unlock: cover property (rd_valid ##[1:20] wr_en);

endmodule

/* File: rtc_control_status_irq_tb.sv */
// self-checking testbench of the clock control and status block
`timescale 1ns/100ps
module rtc_control_status_irq_tb;
  import rcs_pkg::*;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

  // ****************************************************************
  // signals and model state
  // ****************************************************************
  localparam int LIMIT = 90000;
  logic i_core_clk, i_rst_n, i_por_n, i_supply_low, i_hsel, i_hwrite;
  logic [31:0] i_haddr, i_hwdata, o_hrdata;
  logic [1:0] i_htrans;
  logic [2:0] i_hsize;
  logic o_hreadyout, o_hresp, o_irq_n;
  logic [7:0] rd, v, seed;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0, p, m_b;
  int q[$];

  rcs_ctrl #(.BASE_DIV_P(1)) u_rcs_ctrl (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_por_n(i_por_n),
    .i_supply_low(i_supply_low),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hsize(i_hsize),
    .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .o_hrdata(o_hrdata),
    .o_irq_n(o_irq_n)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // periodic spacing in time base ticks, one tick per cycle here
  function automatic int period(input int c);
    return c >= 3 ? 1 << (c - 1) : 64 << c;
  endfunction

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // single word transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d);
    i_hsel <= 1'b1;
    i_haddr <= {22'h0, idx, 2'b00};
    i_htrans <= 2'h2;
    i_hwrite <= wr;
    @(posedge i_core_clk);
    while (o_hreadyout !== 1'b1) @(posedge i_core_clk);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= {24'h0, d};
    @(posedge i_core_clk);
    while (o_hreadyout !== 1'b1) @(posedge i_core_clk);
    rd = o_hrdata[7:0];
  endtask

  // read flags until the periodic flag shows, note the cycle
  task automatic poll(input int lim);
    int k;
    k = 0;
    bus(1'b0, IDX_FLAGS, 8'h00);
    while (rd[6] !== 1'b1 && k < lim) begin
      bus(1'b0, IDX_FLAGS, 8'h00);
      k += 2;
    end
    q.push_back(cyc);
  endtask

  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      summarize();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    i_rst_n = 1'b0;
    i_por_n = 1'b0;
    i_supply_low = 1'b0;
    i_hsel = 1'b0;
    i_haddr = 32'h0;
    i_htrans = 2'h0;
    i_hwrite = 1'b0;
    i_hsize = HSIZE_WORD;
    i_hwdata = 32'h0;
    seed = 8'h2e;
    repeat (10) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    i_por_n <= 1'b1;
    t0 = cyc;
    // locked until validity read
    bus(1'b1, IDX_CTRL_B, 8'h70);
    bus(1'b0, IDX_CTRL_B, 8'h00);
    `CHK(rd, CTRL_B_RESET)
    bus(1'b0, IDX_VALID, 8'h00);
    `CHK(rd, 8'h00)
    bus(1'b1, IDX_VALID, 8'h00);
    bus(1'b0, IDX_VALID, 8'h00);
    `CHK(rd, 8'h80)
    bus(1'b0, 8'h3f, 8'h00);
    `CHK(rd, 8'h00)
    `CHK(o_hresp, 1'b0)
    // spring forward at the first second, alarm on the new time
    bus(1'b1, IDX_CTRL_B, 8'h3b);
    bus(1'b0, IDX_CTRL_B, 8'h00);
    `CHK(rd, 8'h33)
    bus(1'b1, IDX_ALM_HOUR, 8'h03);
    bus(1'b1, IDX_MONTH, 8'h04);
    bus(1'b1, IDX_DATE, 8'h01);
    bus(1'b1, IDX_HOUR, 8'h01);
    bus(1'b1, IDX_MIN, 8'h59);
    bus(1'b1, IDX_SEC, 8'h59);
    while (o_irq_n !== 1'b0 && cyc - t0 < 33000) @(posedge i_core_clk);
    `CHK((cyc - t0) inside {[32760:32800]}, 1'b1)
    repeat (2) @(posedge i_core_clk);
    `CHK(o_irq_n, 1'b0)
    bus(1'b0, IDX_FLAGS, 8'h00);
    `CHK(rd, 8'hf0)
    `CHK(o_irq_n, 1'b1)
    bus(1'b0, IDX_SEC, 8'h00);
    `CHK(rd, 8'h00)
    bus(1'b0, IDX_MIN, 8'h00);
    `CHK(rd, 8'h00)
    bus(1'b0, IDX_HOUR, 8'h00);
    `CHK(rd, 8'h03)
    // every rate code, spacing measured between two flags for codes 1 to 12, time frozen
    bus(1'b1, IDX_CTRL_B, 8'hc2);
    for (int c = 1; c < 16; c++) begin
      p = period(c);
      bus(1'b1, IDX_CTRL_A, 8'(c));
      bus(1'b0, IDX_FLAGS, 8'h00);
      poll(p + 8);
      `CHK(rd[7:6], 2'h3)
      if (p <= 2048) begin
        poll(p + 8);
        `CHK(q[$] - q[$-1], p)
      end
    end
    bus(1'b0, IDX_SEC, 8'h00);
    `CHK(rd, 8'h00)
    bus(1'b1, IDX_CTRL_A, 8'h00);
    bus(1'b0, IDX_FLAGS, 8'h00);
    repeat (600) @(posedge i_core_clk);
    bus(1'b0, IDX_FLAGS, 8'h00);
    `CHK(rd[7:6], 2'h0)
    `CHK(o_irq_n, 1'b1)
    // supply drop
    i_supply_low <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    i_supply_low <= 1'b0;
    @(posedge i_core_clk);
    bus(1'b0, IDX_VALID, 8'h00);
    `CHK(rd, 8'h00)
    bus(1'b0, IDX_VALID, 8'h00);
    `CHK(rd, 8'h80)
    // random option bits, freeze kept off
    repeat (4) begin
      seed = lfsr(seed);
      v = seed & 8'h7f;
      bus(1'b1, IDX_CTRL_B, v);
      bus(1'b0, IDX_CTRL_B, 8'h00);
      m_b = v & 8'hf7;
      `CHK(rd, m_b[7:0])
      bus(1'b1, IDX_FLAGS, seed);
      bus(1'b0, IDX_FLAGS, 8'h00);
      `CHK(rd[3:0], 4'h0)
    end
    // master reset keeps options, clears enables and flags
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    bus(1'b0, IDX_CTRL_B, 8'h00);
    m_b = m_b & 8'h8f;
    `CHK(rd, m_b[7:0])
    bus(1'b0, IDX_FLAGS, 8'h00);
    `CHK(rd, 8'h00)
    summarize();
  end
endmodule
